// ===== design/fpag_gate.sv
// Flash access gate, bank switch and routine download sequencer with AHB-Lite registers.
//
// Implementation choices: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`include "fpag_regs.svh"
module fpag_gate (
	input wire logic ref_clk, // System clock, 100 MHz.
	input wire logic reset, // Synchronous reset, active high.
	input wire logic ce, // Clock enable; all state holds while low.
	input wire logic hsel, // AHB slave select.
	input wire logic [1:0] htrans, // AHB transfer type.
	input wire logic [31:0] haddr, // AHB address.
	input wire logic hwrite, // AHB write flag.
	input wire logic [2:0] hsize, // AHB size, word only.
	input wire logic [31:0] hwdata, // AHB write data.
	input wire logic hready, // AHB bus ready.
	output logic hreadyout, // Slave ready, always high.
	output logic hresp, // Slave response, always OKAY.
	output logic [31:0] hrdata, // Read data.
	input wire logic [31:0] emb_rd_data, // Embedded routine word at emb_rd_addr.
	output logic [4:0] emb_rd_addr, // Embedded routine word index.
	output fpag_pkg::fpag_ram_wr_type ram_wr, // RAM write port for the routine.
	output fpag_pkg::fpag_bank_type bank_sel, // Mapped flash bank.
	output logic flash_block, // High while CPU flash access is refused.
	output logic flash_op_start, // One-cycle start pulse to the flash macro.
	output logic flash_op_erase, // Operation kind: 1 erase, 0 program.
	input wire logic flash_op_done, // One-cycle done pulse from the flash macro.
	output logic irq // Level interrupt.
);
	fpag_pkg::fpag_state_type state_reg;
	fpag_pkg::fpag_aph_type aph_reg;
	fpag_pkg::fpag_ram_wr_type ram_reg;
	logic [7:0] key_reg;
	logic [31:0] dest_reg, src_reg, hrdata_reg;
	logic asel_reg, dl_done_reg, op_err_reg, blk_hold_reg, op_start_reg, op_erase_reg;
	logic [2:0] ista_reg, ien_reg, ev;
	logic [4:0] idx_reg;
	logic dl_go, op_go, prog_req, erase_req, src_in_flash, dl_done_ev, op_done_ev, src_err_ev;

	// ----------------------------------------------------------------
	// Bus slave.
	// ----------------------------------------------------------------
	// True when a data-phase write targets the given offset.
	function automatic logic wr_hit(input fpag_pkg::fpag_aph_type a, input logic [7:0] off);
		wr_hit = a.valid && a.write && (a.addr == off);
	endfunction

	// Zero wait states: every transfer finishes in its first data-phase cycle.
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_reg;

	// Capture the address phase and prepare read data for the data phase.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			aph_reg <= '0;
			hrdata_reg <= 32'h0000_0000;
		end else if (ce) begin
			aph_reg.valid <= hsel && htrans[1] && hready;
			aph_reg.write <= hwrite;
			aph_reg.addr <= haddr[7:0];
			if (hsel && htrans[1] && hready && !hwrite) begin
				unique case (haddr[7:0])
					`FPAG_OFF_KEY: hrdata_reg <= {24'h00_0000, key_reg};
					`FPAG_OFF_CCS: hrdata_reg <= {29'h0, dl_done_reg,
						state_reg == fpag_pkg::ST_DL_RUN, 1'b0};
					`FPAG_OFF_DEST: hrdata_reg <= dest_reg;
					`FPAG_OFF_ASEL: hrdata_reg <= {31'h0, asel_reg};
					`FPAG_OFF_SRC: hrdata_reg <= src_reg;
					`FPAG_OFF_OPCTL: hrdata_reg <= {27'h0, flash_block, op_err_reg,
						state_reg == fpag_pkg::ST_OP_RUN, 2'b00};
					`FPAG_OFF_ISTAT: hrdata_reg <= {29'h0, ista_reg};
					`FPAG_OFF_IEN: hrdata_reg <= {29'h0, ien_reg};
					default: hrdata_reg <= 32'h0000_0000;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Software registers.
	// ----------------------------------------------------------------
	// The destination is frozen during a download so the reserved RAM window cannot move.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			key_reg <= `FPAG_KEY_RST;
			dest_reg <= `FPAG_DEST_RST;
			src_reg <= 32'h0000_0000;
			asel_reg <= 1'b0;
			ien_reg <= 3'h0;
		end else if (ce) begin
			if (wr_hit(aph_reg, `FPAG_OFF_KEY))
				key_reg <= hwdata[7:0];
			if (wr_hit(aph_reg, `FPAG_OFF_DEST) && state_reg != fpag_pkg::ST_DL_RUN)
				dest_reg <= hwdata; // [RQ1]
			if (wr_hit(aph_reg, `FPAG_OFF_SRC))
				src_reg <= hwdata;
			if (wr_hit(aph_reg, `FPAG_OFF_ASEL))
				asel_reg <= hwdata[0];
			if (wr_hit(aph_reg, `FPAG_OFF_IEN))
				ien_reg <= hwdata[2:0];
		end
	end

	// ----------------------------------------------------------------
	// Start decoding.
	// ----------------------------------------------------------------
	// Starts are honoured only from idle and with the matching key value.
	assign dl_go = wr_hit(aph_reg, `FPAG_OFF_CCS) && hwdata[`FPAG_CCS_START]
		&& key_reg == `FPAG_KEY_DL && state_reg == fpag_pkg::ST_IDLE;
	assign prog_req = wr_hit(aph_reg, `FPAG_OFF_OPCTL) && hwdata[`FPAG_OP_PROG];
	assign erase_req = wr_hit(aph_reg, `FPAG_OFF_OPCTL) && hwdata[`FPAG_OP_ERASE];
	assign src_in_flash = src_reg >= `FPAG_FLASH_LO && src_reg <= `FPAG_FLASH_HI;
	assign src_err_ev = prog_req && !erase_req && src_in_flash && key_reg == `FPAG_KEY_OP
		&& state_reg == fpag_pkg::ST_IDLE; // [RQ9]
	assign op_go = (erase_req || (prog_req && !src_in_flash)) && key_reg == `FPAG_KEY_OP
		&& state_reg == fpag_pkg::ST_IDLE;
	assign dl_done_ev = state_reg == fpag_pkg::ST_DL_RUN && idx_reg == `FPAG_ROUTINE_WORDS;
	assign op_done_ev = state_reg == fpag_pkg::ST_OP_RUN && flash_op_done;

	// ----------------------------------------------------------------
	// Sequencer and routine copy.
	// ----------------------------------------------------------------
	// One word per cycle moves from embedded storage into RAM at the destination window.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			state_reg <= fpag_pkg::ST_IDLE;
			idx_reg <= 5'h00;
			ram_reg <= '0;
			op_start_reg <= 1'b0;
			op_erase_reg <= 1'b0;
		end else if (ce) begin
			op_start_reg <= op_go;
			ram_reg.we <= 1'b0;
			unique case (state_reg)
				fpag_pkg::ST_IDLE: begin
					idx_reg <= 5'h00;
					if (dl_go) begin
						state_reg <= fpag_pkg::ST_DL_RUN;
					end else if (op_go) begin
						state_reg <= fpag_pkg::ST_OP_RUN;
						op_erase_reg <= erase_req;
					end
				end
				fpag_pkg::ST_DL_RUN: begin
					if (dl_done_ev) begin
						state_reg <= fpag_pkg::ST_IDLE;
					end else begin
						ram_reg.we <= 1'b1; // [RQ1]
						ram_reg.addr <= dest_reg + {25'h000_0000, idx_reg, 2'b00};
						ram_reg.data <= emb_rd_data;
						idx_reg <= idx_reg + 5'h01;
					end
				end
				fpag_pkg::ST_OP_RUN: begin
					if (op_done_ev)
						state_reg <= fpag_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// Download result and operation error flags; a new start clears the old result.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			dl_done_reg <= 1'b0;
			op_err_reg <= 1'b0;
		end else if (ce) begin
			if (dl_done_ev)
				dl_done_reg <= 1'b1;
			else if (dl_go)
				dl_done_reg <= 1'b0;
			if (src_err_ev)
				op_err_reg <= 1'b1; // [RQ9]
			else if (op_go)
				op_err_reg <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Flash access gating and bank mapping.
	// ----------------------------------------------------------------
	// The block outlives the operation until software writes the key back to zero.
	always_ff @(posedge ref_clk) begin
		if (reset)
			blk_hold_reg <= 1'b0;
		else if (ce)
			blk_hold_reg <= op_done_ev || (blk_hold_reg && key_reg != `FPAG_KEY_RST); // [RQ6]
	end

	// Download leaves flash open; only a running operation or the hold closes it.
	assign flash_block = state_reg == fpag_pkg::ST_OP_RUN || blk_hold_reg; // [RQ4] [RQ5] [RQ6]
	// The embedded bank is mapped for the whole download, then the selected array returns.
	assign bank_sel = (state_reg == fpag_pkg::ST_DL_RUN) ? fpag_pkg::BANK_EMB
		: (asel_reg ? fpag_pkg::BANK_BOOT : fpag_pkg::BANK_USER); // [RQ3]
	assign emb_rd_addr = idx_reg;
	assign ram_wr = ram_reg;
	assign flash_op_start = op_start_reg;
	assign flash_op_erase = op_erase_reg;

	// ----------------------------------------------------------------
	// Interrupts.
	// ----------------------------------------------------------------
	// A new event in the clearing cycle survives because the set term is ORed last.
	assign ev = {src_err_ev, op_done_ev, dl_done_ev};
	always_ff @(posedge ref_clk) begin
		if (reset)
			ista_reg <= 3'h0;
		else if (ce)
			ista_reg <= (ista_reg & ~(wr_hit(aph_reg, `FPAG_OFF_ICLR) ? hwdata[2:0] : 3'h0)) | ev;
	end
	assign irq = |(ista_reg & ien_reg);

	// ----------------------------------------------------------------
	// Assertions.
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset || !ce);

	chk_bank_switch: assert property (dl_go |=> bank_sel == fpag_pkg::BANK_EMB [*3]) // [RQ3]
		else $error("Embedded bank not mapped after download start.");
	chk_dl_readable: assert property (state_reg == fpag_pkg::ST_DL_RUN |-> !flash_block) // [RQ4]
		else $error("Flash blocked before download result.");
	chk_op_blocked: assert property (op_go |=> flash_block throughout flash_op_start) // [RQ5]
		else $error("Flash open during operation.");
	chk_hold_block: assert property (op_done_ev ##1 key_reg != `FPAG_KEY_RST |-> flash_block) // [RQ6]
		else $error("Flash reopened before key cleared.");
	chk_src_abort: assert property (src_err_ev |=> !flash_op_start && op_err_reg
		&& ista_reg[`FPAG_IRQ_SRC]) // [RQ9]
		else $error("Flash-sourced programming not aborted.");
	chk_ram_window: assert property (ram_reg.we |-> ram_reg.addr >= dest_reg
		&& ram_reg.addr < dest_reg + 32'h0000_0040) // [RQ1]
		else $error("Routine written outside the destination window.");
	cov_download: cover property (dl_go ##[1:40] dl_done_ev);
	cov_operation: cover property (op_go ##[1:200] op_done_ev);
	cov_src_error: cover property (src_err_ev);
endmodule

// ===== design/fpag_pkg.sv
// Types shared by the flash program access gate.
package fpag_pkg;
	// Sequencer states.
	typedef enum logic [1:0] {ST_IDLE, ST_DL_RUN, ST_OP_RUN} fpag_state_type;
	// Mapped flash bank codes.
	typedef enum logic [1:0] {BANK_USER, BANK_BOOT, BANK_EMB} fpag_bank_type;
	// Captured AHB address phase.
	typedef struct packed {
		logic valid;
		logic write;
		logic [7:0] addr;
	} fpag_aph_type;
	// Write port into on-chip RAM.
	typedef struct packed {
		logic we;
		logic [31:0] addr;
		logic [31:0] data;
	} fpag_ram_wr_type;
endpackage

// ===== design/fpag_regs.svh
// Register offsets, field positions, reset values and counts of the flash program access gate.
//
// Behaviour
// RQ1: The routine is copied into RAM starting at the download destination address.
// RQ2: Software reserves at least 128 bytes of stack for the downloaded routine.
// RQ3: Writing 1 to the download start bit maps the embedded storage bank.
// RQ4: Flash stays readable until the download result is decided.
// RQ5: All flash accesses are blocked while programming or erasure runs.
// RQ6: After programming or erasure, flash stays blocked until the key register clears.
// RQ7: Reset after programming must be held low longer than 100 microseconds.
// RQ8: Software never resets the chip while programming or erasure runs.
// RQ9: A program-data source inside flash aborts programming and reports an error.
// RQ10: In user boot mode, software switches arrays from RAM via array select.
// RQ11: Key A5 precedes download, key 5A precedes operations, then the key clears.
// RQ12: Code, vectors and handlers reside outside flash during programming or erasure.
`ifndef FPAG_REGS_SVH
`define FPAG_REGS_SVH
// ----------------------------------------------------------------
// Register offsets (byte addresses).
// ----------------------------------------------------------------
`define FPAG_OFF_KEY 8'h00
`define FPAG_OFF_CCS 8'h04
`define FPAG_OFF_DEST 8'h08
`define FPAG_OFF_ASEL 8'h0C
`define FPAG_OFF_SRC 8'h10
`define FPAG_OFF_OPCTL 8'h14
`define FPAG_OFF_ISTAT 8'h18
`define FPAG_OFF_ICLR 8'h1C
`define FPAG_OFF_IEN 8'h20
// ----------------------------------------------------------------
// Field positions, key values, reset values and counts.
// ----------------------------------------------------------------
`define FPAG_CCS_START 0
`define FPAG_CCS_BUSY 1
`define FPAG_CCS_DONE 2
`define FPAG_OP_PROG 0
`define FPAG_OP_ERASE 1
`define FPAG_OP_BUSY 2
`define FPAG_OP_ERR 3
`define FPAG_OP_BLOCK 4
`define FPAG_IRQ_DL 0
`define FPAG_IRQ_OP 1
`define FPAG_IRQ_SRC 2
`define FPAG_KEY_DL 8'hA5
`define FPAG_KEY_OP 8'h5A
`define FPAG_KEY_RST 8'h00
`define FPAG_DEST_RST 32'h0000_0000
`define FPAG_FLASH_LO 32'h0000_0000
`define FPAG_FLASH_HI 32'h0003_FFFF
`define FPAG_ROUTINE_WORDS 5'h10
`endif

// ===== verification/fpag_flash_model.sv
// Behavioural model of the embedded routine store and the flash macro.
`timescale 1ns/1ns
module fpag_flash_model (
	input wire logic ref_clk, // System clock.
	input wire logic reset, // Synchronous reset, active high.
	input wire logic [3:0] op_lat, // Cycles from start to done, one at least.
	input wire logic [4:0] emb_rd_addr, // Routine word index.
	output logic [31:0] emb_rd_data, // Routine word.
	input wire logic flash_op_start, // Operation start pulse.
	output logic flash_op_done // Operation done pulse.
);
	logic [3:0] cnt;
	// Each word carries its own index, so a misplaced copy shows at once.
	assign emb_rd_data = {16'hC0DE, 11'h000, emb_rd_addr};
	// The macro answers op_lat cycles after a start; zero means no operation.
	always_ff @(posedge ref_clk) begin
		flash_op_done <= 1'b0;
		if (reset) begin
			cnt <= 4'h0;
		end else if (flash_op_start) begin
			cnt <= op_lat;
		end else if (cnt == 4'h1) begin
			cnt <= 4'h0;
			flash_op_done <= 1'b1;
		end else if (cnt != 4'h0) begin
			cnt <= cnt - 4'h1;
		end
	end
endmodule

// ===== verification/testbench.sv
// Self-checking testbench of the flash program access gate.
`timescale 1ns/1ns
`include "fpag_regs.svh"
module testbench;
	// ----------------------------------------------------------------
	// Stimulus, design and partner.
	// ----------------------------------------------------------------
	logic ref_clk = 0, reset = 1, ce = 1, hsel = 0, hwrite = 0, hrdy, hresp, start, erase, done;
	logic blk, irq;
	logic [1:0] htrans = 2'b00;
	logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, rdat, q, dest;
	logic [3:0] lat = 4'h1;
	logic [4:0] eaddr;
	fpag_pkg::fpag_ram_wr_type ram_wr;
	fpag_pkg::fpag_bank_type bank;
	int n_errors = 0, n_tests = 0, n_words = 0, n_starts = 0, i;
	fpag_gate i_fpag_gate (.ref_clk(ref_clk), .reset(reset), .ce(ce), .hsel(hsel),
		.htrans(htrans), .haddr(haddr), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hrdy), .hreadyout(hrdy), .hresp(hresp), .hrdata(hrdata), .emb_rd_data(rdat),
		.emb_rd_addr(eaddr), .ram_wr(ram_wr), .bank_sel(bank), .flash_block(blk),
		.flash_op_start(start), .flash_op_erase(erase), .flash_op_done(done), .irq(irq));
	fpag_flash_model i_fpag_flash_model (.ref_clk(ref_clk), .reset(reset), .op_lat(lat),
		.emb_rd_addr(eaddr), .emb_rd_data(rdat), .flash_op_start(start), .flash_op_done(done));
	// Clock of 100 MHz.
	initial begin
		forever #5 ref_clk = ~ref_clk;
	end
	// ----------------------------------------------------------------
	// Shared tasks.
	// ----------------------------------------------------------------
	task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			$display("Error %s expected %h seen %h", name, exp, got);
			n_errors++;
		end
	endtask
	// One AHB-Lite single word transfer; waits on hready, never on a fixed count.
	task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h00_0000, a};
		hwrite <= wr;
		@(posedge ref_clk);
		while (hrdy !== 1'b1) @(posedge ref_clk);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		@(posedge ref_clk);
		while (hrdy !== 1'b1) @(posedge ref_clk);
		q = hrdata;
	endtask
	task end_of_test;
		$display("Checks %0d, errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// Every copied word is judged as it leaves; flash must stay readable meanwhile.
	always @(posedge ref_clk) begin
		if (start === 1'b1) n_starts++;
		if (ram_wr.we === 1'b1) begin
			chk("ram_addr", dest + 32'(n_words * 4), ram_wr.addr);
			chk("ram_data", {16'hC0DE, 11'h000, 5'(n_words)}, ram_wr.data);
			chk("bank_dl", 32'(fpag_pkg::BANK_EMB), 32'(bank));
			chk("block_dl", 32'h0000_0000, 32'(blk));
			n_words++;
		end
	end
	// ----------------------------------------------------------------
	// Scenarios.
	// ----------------------------------------------------------------
	task t_download;
		dest = 32'h2000_0100; // The stack keeps 128 bytes below this window.
		bus(1, `FPAG_OFF_DEST, dest);
		bus(1, `FPAG_OFF_CCS, 32'h0000_0001); // Refused: the key is still clear.
		bus(0, `FPAG_OFF_CCS, 32'h0000_0000);
		chk("dl_refused", 32'h0000_0000, q & 32'h0000_0006);
		bus(1, `FPAG_OFF_KEY, 32'h0000_00A5);
		bus(1, `FPAG_OFF_CCS, 32'h0000_0001);
		// A low clock enable must hold the copy where it stands.
		ce <= 1'b0;
		repeat (5) @(posedge ref_clk);
		chk("ce_freeze", 32'h0000_0000, 32'(n_words));
		ce <= 1'b1;
		for (i = 0; i < 40 && n_words < 16; i++) @(posedge ref_clk);
		repeat (3) @(posedge ref_clk);
		chk("words", 32'h0000_0010, 32'(n_words));
		chk("bank_idle", 32'(fpag_pkg::BANK_USER), 32'(bank));
		bus(0, `FPAG_OFF_CCS, 32'h0000_0000);
		chk("dl_done", 32'h0000_0004, q & 32'h0000_0006);
	endtask
	task t_src_err;
		bus(1, `FPAG_OFF_KEY, 32'h0000_005A);
		bus(1, `FPAG_OFF_SRC, `FPAG_FLASH_HI);
		bus(1, `FPAG_OFF_OPCTL, 32'h0000_0001);
		bus(0, `FPAG_OFF_OPCTL, 32'h0000_0000);
		chk("src_err", 32'h0000_0008, q & 32'h0000_001C);
		chk("no_start", 32'h0000_0000, 32'(n_starts));
		bus(0, `FPAG_OFF_ISTAT, 32'h0000_0000);
		chk("src_irq", 32'h0000_0004, q & 32'h0000_0004);
	endtask
	// Program with a prompt macro, then erase with a slow one.
	task t_ops;
		bus(1, `FPAG_OFF_SRC, 32'h2000_0000); // Program data sits in RAM, outside flash.
		for (int k = 0; k < 2; k++) begin
			lat <= k ? 4'h9 : 4'h1;
			bus(1, `FPAG_OFF_KEY, 32'h0000_005A);
			bus(1, `FPAG_OFF_OPCTL, k ? 32'h0000_0003 : 32'h0000_0001);
			// The start edge launches the outputs; judge them one edge later.
			@(posedge ref_clk);
			chk("erase", 32'(k), 32'(erase));
			for (i = 0; i < 20 && done !== 1'b1; i++) begin
				chk("block_run", 32'h0000_0001, 32'(blk));
				@(posedge ref_clk);
			end
			repeat (4) @(posedge ref_clk);
			chk("block_hold", 32'h0000_0001, 32'(blk));
			bus(1, `FPAG_OFF_KEY, 32'h0000_0000);
			for (i = 0; i < 5 && blk !== 1'b0; i++) @(posedge ref_clk);
			chk("block_free", 32'h0000_0000, 32'(blk));
		end
		chk("starts", 32'h0000_0002, 32'(n_starts));
	endtask
	task t_irq_misc;
		bus(1, `FPAG_OFF_IEN, 32'h0000_0000);
		chk("irq_masked", 32'h0000_0000, 32'(irq));
		bus(1, `FPAG_OFF_IEN, 32'h0000_0002);
		@(posedge ref_clk);
		chk("irq_on", 32'h0000_0001, 32'(irq));
		bus(1, `FPAG_OFF_ICLR, 32'h0000_0007);
		bus(0, `FPAG_OFF_ISTAT, 32'h0000_0000);
		chk("irq_clr", 32'h0000_0000, q | 32'(irq));
		bus(1, `FPAG_OFF_ASEL, 32'h0000_0001);
		@(posedge ref_clk);
		chk("bank_boot", 32'(fpag_pkg::BANK_BOOT), 32'(bank));
		bus(0, 8'h40, 32'h0000_0000);
		chk("unmapped", 32'h0000_0000, q);
	endtask
	// A reset held past 100 microseconds after the operations must restore the default bank, interrupt line and key.
	task t_reset;
		bus(1, `FPAG_OFF_KEY, 32'h0000_00A5);
		reset <= 1'b1; // No operation is running at this point.
		repeat (10001) @(posedge ref_clk);
		reset <= 1'b0;
		@(posedge ref_clk);
		chk("bank_rst", 32'(fpag_pkg::BANK_USER), 32'(bank));
		chk("irq_rst", 32'h0000_0000, 32'(irq));
		bus(0, `FPAG_OFF_KEY, 32'h0000_0000);
		chk("key_rst2", 32'h0000_0000, q);
	endtask
	// Watchdog that ends a hang.
	initial begin
		#200000;
		n_errors++;
		end_of_test();
	end
	// Main sequence.
	initial begin
		repeat (3) @(posedge ref_clk);
		reset <= 1'b0;
		@(posedge ref_clk);
		bus(0, `FPAG_OFF_KEY, 32'h0000_0000);
		chk("key_rst", 32'h0000_0000, q);
		chk("hresp", 32'h0000_0000, 32'(hresp));
		t_download();
		t_src_err();
		t_ops();
		t_irq_misc();
		t_reset();
		end_of_test();
	end
endmodule
